// file: ssd_status.sv
// Contract
// - when error lamp lit, show type lamp and node number on 8-4-2-1 lamps.
// - a multi-node slave may be shown under any node it occupies.
// - hold first error on display; advance only after it is cleared.
// - sixteen-slave setting uses two status words.
// - thirty-two-slave setting uses four status words.
// - first host family base word is 2000 plus ten times unit.
// - other family: 100+10u for units 0-9, else 400+10(u-10).
// - all active and error flags clear at power-up and restart.
// - active flag sets on first participation and stays set.
// - error flag set when withdrawn for failure, else zero.
// - hold last input data of a slave while its error flag is set.
// - pass slave input or output only after its active flag is on.
// - with simultaneous errors display the one recognised first; code advances to lowest pending input, then output node.
module ssd_status (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EVT_VALID,
  input wire logic EVT_FAIL,
  input wire logic EVT_OUTPUT,
  input wire logic [3:0] EVT_NODE,
  input wire logic RX_VALID,
  input wire logic [3:0] RX_NODE,
  input wire logic [7:0] RX_DATA,
  input wire logic MAX32_PIN,
  input wire logic FAMILY_PIN,
  input wire logic [3:0] UNIT_PIN,
  output logic [15:0] TX_ENABLE,
  output logic [15:0] STATUS_BASE,
  output logic COMM_ERROR_INDICATOR,
  output logic IO_INDICATOR,
  output logic [3:0] NODE_INDICATOR,
  output logic IRQ
);
  typedef struct packed {
    ssd_pkg::ssd_apb_t st;
    logic [31:0] rdata;
    logic rerr;
    logic [15:0] in_act;
    logic [15:0] in_err;
    logic [15:0] out_act;
    logic [15:0] out_err;
    logic disp_busy;
    logic disp_out;
    logic [3:0] disp_node;
    logic [ssd_pkg::IRQ_W-1:0] irq_stat;
    logic [ssd_pkg::IRQ_W-1:0] irq_mask;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] strap;
    logic [15:0] base;
  } ssd_state_t;

  ssd_state_t s_q, s_d;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic bus_wr;

  // status area base word for a unit number and host family
  function automatic logic [15:0] base_word(input logic fam_b,
                                            input logic [3:0] unit);
    logic [15:0] u;
    u = {12'h000, unit};
    if (!fam_b) begin
      base_word = 16'(ssd_pkg::BASE_FAM_A + u * ssd_pkg::BASE_STEP);
    end else if (unit < ssd_pkg::UNIT_SPLIT) begin
      base_word = 16'(ssd_pkg::BASE_FAM_B_LO + u * ssd_pkg::BASE_STEP);
    end else begin
      base_word = 16'(ssd_pkg::BASE_FAM_B_HI
                      + (u - 16'(ssd_pkg::UNIT_SPLIT)) * ssd_pkg::BASE_STEP);
    end
  endfunction

  // lowest set bit of a flag vector, with a found flag
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    first_set = r;
  endfunction

  // 16-bit status word from active and error halves
  function automatic logic [15:0] status_word(input logic [7:0] act,
                                              input logic [7:0] err);
    // error flags high byte, active flags low byte
    status_word = {err, act};
  endfunction

  logic max32;
  logic fam_b;
  logic [3:0] unit;
  assign max32 = s_q.strap[5];
  assign fam_b = s_q.strap[4];
  assign unit = s_q.strap[3:0];

  logic node_ok;
  assign node_ok = max32 || (EVT_NODE <= ssd_pkg::NODES16_LAST);
  logic rx_ok;
  assign rx_ok = max32 || (RX_NODE <= ssd_pkg::NODES16_LAST);

  // stale input kept while error flag set
  // input taken only from an active slave
  assign mem_we = RX_VALID && rx_ok && s_q.in_act[RX_NODE]
                  && !s_q.in_err[RX_NODE];

  ssd_mem u_mem (
    .clk(MCLK),
    .rst(RESET),
    .we(mem_we),
    .waddr(RX_NODE),
    .wdata(RX_DATA),
    .raddr(PADDR[5:2]),
    .rdata_q(mem_rdata)
  );

  assign bus_wr = (s_q.st == ssd_pkg::ST_DONE) && PSEL && PENABLE
                  && PWRITE;

  always_comb begin
    logic [5:0] idx;
    logic [4:0] pick;
    logic restart;
    logic ev_fail;
    logic ev_join;
    logic [31:0] rd;
    logic rerr;
    idx = PADDR[7:2];
    pick = 5'h00;
    restart = 1'b0;
    ev_fail = 1'b0;
    ev_join = 1'b0;
    rd = 32'h0000_0000;
    rerr = 1'b0;
    s_d = s_q;

    // strap pins: accepted once the second and third stage agree
    s_d.sync1 = {MAX32_PIN, FAMILY_PIN, UNIT_PIN};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    if (s_q.sync2 == s_q.sync3) begin
      s_d.strap = s_q.sync3;
    end
    s_d.base = base_word(fam_b, unit);

    // register writes take effect on the completing edge
    if (bus_wr) begin
      case (idx)
        ssd_pkg::IDX_IRQ_STAT: begin
          s_d.irq_stat = s_q.irq_stat & ~PWDATA[ssd_pkg::IRQ_W-1:0];
        end
        ssd_pkg::IDX_IRQ_MASK: begin
          s_d.irq_mask = PWDATA[ssd_pkg::IRQ_W-1:0];
        end
        ssd_pkg::IDX_CTRL: begin
          restart = PWDATA[ssd_pkg::CTRL_RESTART_BIT];
        end
        default: begin
        end
      endcase
    end

    if (restart) begin
      s_d.in_act = ssd_pkg::FLAGS_RST;
      s_d.in_err = ssd_pkg::FLAGS_RST;
      s_d.out_act = ssd_pkg::FLAGS_RST;
      s_d.out_err = ssd_pkg::FLAGS_RST;
    end

    // slave events come after a restart clear, so a coincident join wins
    if (EVT_VALID && node_ok) begin
      if (EVT_FAIL) begin
        // failure of a participating slave withdraws it
        if (EVT_OUTPUT && s_d.out_act[EVT_NODE]) begin
          s_d.out_err[EVT_NODE] = 1'b1;
          ev_fail = 1'b1;
        end else if (!EVT_OUTPUT && s_d.in_act[EVT_NODE]) begin
          s_d.in_err[EVT_NODE] = 1'b1;
          ev_fail = 1'b1;
        end
      end else begin
        // active flag sets on joining and is cleared only by reset or a restart
        if (EVT_OUTPUT) begin
          s_d.out_act[EVT_NODE] = 1'b1;
          s_d.out_err[EVT_NODE] = 1'b0;
        end else begin
          s_d.in_act[EVT_NODE] = 1'b1;
          s_d.in_err[EVT_NODE] = 1'b0;
        end
        ev_join = 1'b1;
      end
    end

    // events set after the clear so a coincident event is kept
    if (ev_fail) begin
      s_d.irq_stat[ssd_pkg::IRQ_FAIL_BIT] = 1'b1;
    end
    if (ev_join) begin
      s_d.irq_stat[ssd_pkg::IRQ_JOIN_BIT] = 1'b1;
    end

    // drop the shown node once its error flag is gone
    if (s_q.disp_busy) begin
      if (s_q.disp_out ? !s_d.out_err[s_q.disp_node]
                       : !s_d.in_err[s_q.disp_node]) begin
        s_d.disp_busy = 1'b0;
      end
    end else begin
      // a fresh failure is shown ahead of older pending ones
      if (ev_fail) begin
        s_d.disp_busy = 1'b1;
        s_d.disp_out = EVT_OUTPUT;
        s_d.disp_node = EVT_NODE;
      end else begin
        // advance to a pending error, inputs first, lowest node
        pick = first_set(s_q.in_err);
        if (pick[4]) begin
          s_d.disp_busy = 1'b1;
          s_d.disp_out = 1'b0;
          s_d.disp_node = pick[3:0];
        end else begin
          pick = first_set(s_q.out_err);
          if (pick[4]) begin
            s_d.disp_busy = 1'b1;
            s_d.disp_out = 1'b1;
            s_d.disp_node = pick[3:0];
          end
        end
      end
    end

    // read mux; memory data is valid one cycle after setup
    if (idx[5:4] == ssd_pkg::IDX_MEM_HI) begin
      rd = {24'h000000, mem_rdata};
    end else begin
      case (idx)
        ssd_pkg::IDX_OUT_LO: begin
          rd = {16'h0000, status_word(s_q.out_act[7:0], s_q.out_err[7:0])};
        end
        ssd_pkg::IDX_IN_LO: begin
          rd = {16'h0000, status_word(s_q.in_act[7:0], s_q.in_err[7:0])};
        end
        // high words unused in the sixteen-slave setting
        // four words in the thirty-two-slave setting
        ssd_pkg::IDX_OUT_HI: begin
          if (max32) begin
            rd = {16'h0000,
                  status_word(s_q.out_act[15:8], s_q.out_err[15:8])};
          end
        end
        ssd_pkg::IDX_IN_HI: begin
          if (max32) begin
            rd = {16'h0000,
                  status_word(s_q.in_act[15:8], s_q.in_err[15:8])};
          end
        end
        ssd_pkg::IDX_IRQ_STAT: begin
          rd = {30'h00000000, s_q.irq_stat};
        end
        ssd_pkg::IDX_IRQ_MASK: begin
          rd = {30'h00000000, s_q.irq_mask};
        end
        ssd_pkg::IDX_DISPLAY: begin
          rd = {26'h0000000, s_q.disp_busy, s_q.disp_out, s_q.disp_node};
        end
        ssd_pkg::IDX_CONFIG: begin
          rd = {14'h0000, fam_b, max32, s_q.base};
        end
        ssd_pkg::IDX_CTRL: begin
          rd = 32'h0000_0000;
        end
        default: begin
          rerr = 1'b1;
        end
      endcase
    end

    // apb access: one wait state, ready in the second access cycle
    case (s_q.st)
      ssd_pkg::ST_IDLE: begin
        if (PSEL && !PENABLE) begin
          s_d.st = ssd_pkg::ST_READ;
        end
      end
      ssd_pkg::ST_READ: begin
        s_d.rdata = PWRITE ? 32'h0000_0000 : rd;
        s_d.rerr = rerr;
        s_d.st = ssd_pkg::ST_DONE;
      end
      ssd_pkg::ST_DONE: begin
        s_d.st = ssd_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = ssd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s_q <= '0;
      s_q.st <= ssd_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign PREADY = (s_q.st == ssd_pkg::ST_DONE) && PSEL && PENABLE;
  assign PRDATA = s_q.rdata;
  assign PSLVERR = PREADY && s_q.rerr;
  // output to a slave enabled only once it is active
  assign TX_ENABLE = s_q.out_act;
  assign STATUS_BASE = s_q.base;
  // type and binary node number while the error lamp is lit
  // the reported node is the one the failure event named
  assign COMM_ERROR_INDICATOR = s_q.disp_busy;
  assign IO_INDICATOR = s_q.disp_busy && s_q.disp_out;
  assign NODE_INDICATOR = s_q.disp_busy ? s_q.disp_node : 4'h0;
  assign IRQ = |(s_q.irq_stat & s_q.irq_mask);
endmodule

// file: ssd_pkg.sv
package ssd_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_OUT_LO = 6'h10;
  localparam logic [5:0] IDX_IN_LO = 6'h11;
  localparam logic [5:0] IDX_OUT_HI = 6'h12;
  localparam logic [5:0] IDX_IN_HI = 6'h13;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h14;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h15;
  localparam logic [5:0] IDX_DISPLAY = 6'h16;
  localparam logic [5:0] IDX_CONFIG = 6'h17;
  localparam logic [5:0] IDX_CTRL = 6'h18;
  // input data words of input slaves 0..15 at indices 0x20..0x2F
  localparam logic [1:0] IDX_MEM_HI = 2'h2;

  // status word layout
  localparam int ACT_LSB = 0;
  localparam int ERR_LSB = 8;

  // interrupt status bits
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_JOIN_BIT = 1;
  localparam int IRQ_W = 2;

  // control and config bits
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_MAX32_BIT = 16;
  localparam int CFG_FAMILY_BIT = 17;

  // reset values
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // status area base word arithmetic
  localparam logic [15:0] BASE_FAM_A = 16'h07D0;
  localparam logic [15:0] BASE_FAM_B_LO = 16'h0064;
  localparam logic [15:0] BASE_FAM_B_HI = 16'h0190;
  localparam logic [15:0] BASE_STEP = 16'h000A;
  localparam logic [3:0] UNIT_SPLIT = 4'hA;

  // last node number in the 16-slave configuration
  localparam logic [3:0] NODES16_LAST = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_DONE = 3'b100
  } ssd_apb_t;
endpackage

// file: ssd_mem.sv
module ssd_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata_q
);
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0] rdata;
  } ssd_mem_t;

  ssd_mem_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.mem[raddr];
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q = s_q.rdata;
endmodule

// file: ssd_status_assertions.sv
module ssd_status_chk (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EVT_VALID,
  input wire logic EVT_FAIL,
  input wire logic EVT_OUTPUT,
  input wire logic [3:0] EVT_NODE,
  input wire logic [15:0] TX_ENABLE,
  input wire logic COMM_ERROR_INDICATOR,
  input wire logic IO_INDICATOR,
  input wire logic [3:0] NODE_INDICATOR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] idx;
  logic ctrl_wr;
  assign idx = PADDR[7:2];
  assign ctrl_wr = PSEL && PENABLE && PWRITE && PREADY
    && idx == ssd_pkg::IDX_CTRL;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  idle_ind_a:
    assert property (!COMM_ERROR_INDICATOR |->
      IO_INDICATOR == 1'b0 && NODE_INDICATOR == 4'h0)
    else $error("indicators lit with no error shown");
  err_show_a:
    assert property ($rose(COMM_ERROR_INDICATOR) && $past(EVT_VALID && EVT_FAIL)
      |-> NODE_INDICATOR == $past(EVT_NODE) && IO_INDICATOR == $past(EVT_OUTPUT))
    else $error("shown node differs from failing node");
  // a clear may take two cycles to advance the display
  err_hold_a:
    assert property (COMM_ERROR_INDICATOR && $past(COMM_ERROR_INDICATOR)
      && !$past(EVT_VALID && !EVT_FAIL) && !$past(EVT_VALID && !EVT_FAIL, 2)
      |-> $stable(NODE_INDICATOR) && $stable(IO_INDICATOR))
    else $error("display moved before first error cleared");
  tx_join_a:
    assert property (EVT_VALID && !EVT_FAIL && EVT_OUTPUT && !EVT_NODE[3]
      |=> ##1 TX_ENABLE[$past(EVT_NODE, 2)])
    else $error("joined output slave not enabled");
  // low byte only: the upper half can only be set in the thirty-two-slave setting
  tx_sticky_a:
    assert property (!$past(ctrl_wr) && !$past(ctrl_wr, 2) |->
      (TX_ENABLE[7:0] & $past(TX_ENABLE[7:0])) == $past(TX_ENABLE[7:0]))
    else $error("enable dropped without restart");
  apb_wait_a:
    assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("answer not after one wait state");
  slverr_map_a:
    assert property (PREADY |-> PSLVERR == !(idx inside {[6'h10:6'h18],
      [6'h20:6'h2F]})) else $error("error response does not match map");
  slverr_ready_a:
    assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error response outside access phase");
  reset_clear_a:
    assert property (disable iff (1'b0) RESET |=>
      TX_ENABLE == 16'h0000 && !COMM_ERROR_INDICATOR && !PREADY)
    else $error("state not clear after reset");
  cover property ($rose(COMM_ERROR_INDICATOR));
  cover property (PREADY && PSLVERR);
  cover property (ctrl_wr);
endmodule
bind ssd_status ssd_status_chk chk_u (.MCLK(MCLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVT_VALID(EVT_VALID),
  .EVT_FAIL(EVT_FAIL), .EVT_OUTPUT(EVT_OUTPUT), .EVT_NODE(EVT_NODE),
  .TX_ENABLE(TX_ENABLE), .COMM_ERROR_INDICATOR(COMM_ERROR_INDICATOR),
  .IO_INDICATOR(IO_INDICATOR), .NODE_INDICATOR(NODE_INDICATOR));

// file: ssd_slaves.sv
module ssd_slaves (
  input wire logic clk,
  output logic ev,
  output logic ef,
  output logic eo,
  output logic [3:0] en,
  output logic rv,
  output logic [3:0] rn,
  output logic [7:0] rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ev, ef, eo, en, rv, rn, rd} = '0;
  // the released event node and receive data lines show the inverse so stale values never match
  task automatic evt(logic f, logic o, logic [3:0] n);
    @(posedge clk);
    {ev, ef, eo, en} <= {1'b1, f, o, n};
    @(posedge clk);
    ev <= 1'b0;
    en <= ~n;
  endtask
  task automatic rx(logic [3:0] n, logic [7:0] d);
    @(posedge clk);
    {rv, rn, rd} <= {1'b1, n, d};
    @(posedge clk);
    rv <= 1'b0;
    rd <= ~d;
  endtask
endmodule

// file: slave_status_error_display_bench.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module slave_status_error_display_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, m32 = 1, fam = 0;
  logic [7:0] pa = 0;
  logic [7:0] rdd;
  logic [31:0] pwd = 0, prd, rd;
  logic prdy, perr, er, ev, ef, eo, rv, ind, io, irq;
  logic [3:0] en, rn, nd, unit = 0;
  logic [15:0] txe, base;
  int fails = 0, check_count = 0, cyc = 0, t, n;
  int act[2][16], err[2][16], dat[16];
  int db = 0, dout = 0, dnode = 0;
  always #10 clk = ~clk;
  ssd_status dut_u (.MCLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .EVT_VALID(ev), .EVT_FAIL(ef), .EVT_OUTPUT(eo),
    .EVT_NODE(en), .RX_VALID(rv), .RX_NODE(rn), .RX_DATA(rdd),
    .MAX32_PIN(m32), .FAMILY_PIN(fam), .UNIT_PIN(unit), .TX_ENABLE(txe),
    .STATUS_BASE(base), .COMM_ERROR_INDICATOR(ind), .IO_INDICATOR(io),
    .NODE_INDICATOR(nd), .IRQ(irq));
  ssd_slaves sl_u (.clk(clk), .ev(ev), .ef(ef), .eo(eo), .en(en), .rv(rv),
    .rn(rn), .rd(rdd));
  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [5:0] i, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, i, 2'b00, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1 && ++k < 9);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 9) begin
      fails++;
      $display("Error %0t: bus answer missing", $time);
    end
  endtask
  task automatic evt(int f, int o, int n);
    sl_u.evt(f[0], o[0], n[3:0]);
    if (f == 0) begin
      act[o][n] = 1;
      err[o][n] = 0;
    end else if (act[o][n] == 1) begin
      err[o][n] = 1;
    end
    // display model: keep the shown error, then lowest pending input first
    if (db != 0 && err[dout][dnode] == 0) begin
      db = 0;
    end else if (db == 0 && f != 0 && act[o][n] == 1) begin
      db = 1;
      dout = o;
      dnode = n;
    end
    if (db == 0) begin
      for (int k = 31; k >= 0; k--) begin
        if (err[k / 16][k % 16] == 1) begin
          db = 1;
          dout = k / 16;
          dnode = k % 16;
        end
      end
    end
  endtask
  task automatic rx(int n, int d);
    sl_u.rx(n[3:0], d[7:0]);
    if (act[0][n] == 1 && err[0][n] == 0) dat[n] = d;
  endtask
  function automatic logic [15:0] exp_word(int w);
    logic [15:0] r;
    for (int n = 0; n < 8; n++) begin
      r[n] = act[!w[0]][n + 8 * w[1]][0];
      r[n + 8] = err[!w[0]][n + 8 * w[1]][0];
    end
    return (w > 1 && !m32) ? 16'h0000 : r;
  endfunction
  function automatic logic [15:0] exp_base(logic f, logic [3:0] u);
    int b;
    b = !f ? 2000 + 10 * u : u < 10 ? 100 + 10 * u : 400 + 10 * (u - 10);
    return b[15:0];
  endfunction
  task automatic chk_words();
    logic [15:0] tx;
    for (int w = 0; w < 4; w++) begin
      apb(1'b0, 6'h10 + 6'(w), 32'h0);
      `CHK(rd, {16'h0000, exp_word(w)})
    end
    for (int n = 0; n < 16; n++) tx[n] = act[1][n][0];
    @(negedge clk);
    `CHK(txe, tx)
  endtask
  // the flag words are always read before the data is trusted
  task automatic chk_data();
    for (int n = 0; n < 16; n++) begin
      apb(1'b0, 6'h20 + 6'(n), 32'h0);
      `CHK(rd, {24'h000000, dat[n][7:0]})
    end
  endtask
  task automatic chk_disp(logic [5:0] e);
    repeat (3) @(negedge clk);
    `CHK({ind, io, nd}, e)
    apb(1'b0, ssd_pkg::IDX_DISPLAY, 32'h0);
    `CHK(rd, {26'h0, db[0], dout[0], dnode[3:0]})
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("Error %0t: run timed out", $time);
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h08A9));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_words();
    chk_data();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fam <= i[0];
      unit <= i[1] ? 4'(10 + $urandom % 5) : 4'($urandom % 10);
      repeat (8) @(posedge clk);
      `CHK(base, exp_base(fam, unit))
      apb(1'b0, ssd_pkg::IDX_CONFIG, 32'h0);
      `CHK(rd, {14'h0, fam, m32, exp_base(fam, unit)})
    end
    repeat (60) begin
      t = $urandom % 4;
      n = $urandom % 16;
      if (t == 3) rx(n, $urandom);
      else evt(t == 2, $urandom % 2, n);
    end
    chk_words();
    chk_data();
    apb(1'b1, 6'h19, 32'hFFFFFFFF);
    `CHK(er, 1'b1)
    apb(1'b0, 6'h19, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, ssd_pkg::IDX_IRQ_MASK, 32'h0);
    apb(1'b1, ssd_pkg::IDX_IRQ_STAT, 32'h3);
    evt(0, 1, 5);
    apb(1'b0, ssd_pkg::IDX_IRQ_STAT, 32'h0);
    `CHK(rd, 32'h2)
    chk_disp({db[0], db[0] & dout[0], db[0] ? dnode[3:0] : 4'h0});
    `CHK(irq, 1'b0)
    apb(1'b1, ssd_pkg::IDX_IRQ_MASK, 32'h2);
    @(negedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, ssd_pkg::IDX_IRQ_STAT, 32'h2);
    @(negedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, ssd_pkg::IDX_CTRL, 32'h1);
    act = '{default: 0};
    err = '{default: 0};
    db = 0;
    chk_words();
    evt(0, 0, 3);
    evt(0, 1, 11);
    evt(1, 0, 3);
    evt(1, 1, 11);
    chk_disp(6'h23);
    evt(0, 0, 3);
    chk_disp(6'h3B);
    evt(0, 1, 11);
    chk_disp(6'h00);
    @(posedge clk);
    m32 <= 1'b0;
    repeat (8) @(posedge clk);
    chk_words();
    stop_test();
  end
endmodule
